/* common/actc_consts.vh */
// Register map, field positions, reset values and timing counts for the channel block
`ifndef ACTC_CONSTS_VH
`define ACTC_CONSTS_VH

`define ACTC_OFS_RSVD       8'hd8
`define ACTC_OFS_RA_COUNT   8'hdc
`define ACTC_OFS_CFG        8'he0
`define ACTC_OFS_PIO        8'he4
`define ACTC_OFS_DMA        8'he8

`define ACTC_RST_RA_COUNT   32'h00000000
`define ACTC_RST_CFG        32'h65150100
`define ACTC_RST_PIO        32'h62dd62dd
`define ACTC_RST_DMA        32'h43924392

`define ACTC_CFG_WD_INT     14
`define ACTC_CFG_WD_EN      13
`define ACTC_CFG_WD_TMO     12
`define ACTC_CFG_IRQ        11
`define ACTC_CFG_BM_DONE    10
`define ACTC_CFG_WATCH      9
`define ACTC_CFG_TRISTATE   3
`define ACTC_CFG_CHRST      2
`define ACTC_CFG_BUFCMD     1
`define ACTC_CFG_CABLE      0

// Writable bits of the config word: timing fields and control bits
`define ACTC_CFG_WMASK      32'hffff620c

`define ACTC_WD_LIMIT       9'h100

`define ACTC_MODE_PIO       2'h0
`define ACTC_MODE_PIO_RDY   2'h1
`define ACTC_MODE_MDMA      2'h2
`define ACTC_MODE_UDMA      2'h3

`endif

/* logic/actc_watchdog.v */
// Wait-line watchdog counter with sticky timeout flag
`timescale 1ns/1ps
`include "actc_consts.vh"
module actc_watchdog (
	input  wire MCLK,
	input  wire RST_N,
	input  wire enable,
	input  wire watch,
	input  wire in_pio,
	input  wire ready,
	input  wire clear,
	output reg  timeout,
	output reg  counting
);
	reg  [8:0] count;
	wire       armed;

	// Monitoring stops while the flag stands
	assign armed = enable & watch & in_pio & ~timeout;

	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			count <= 9'h000;
			timeout <= 1'b0;
			counting <= 1'b0;
		end else begin
			// [RULE23] restart on deassert
			if (!armed || ready) begin
				count <= 9'h000;
				counting <= 1'b0;
			end else if (count == `ACTC_WD_LIMIT - 9'h001) begin
				count <= 9'h000;
				counting <= 1'b0;
			end else begin
				count <= count + 9'h001;
				counting <= 1'b1;
			end
			// [RULE9] 256 clocks expire
			// [RULE10] write-one clear, set wins
			if (armed && !ready && count == `ACTC_WD_LIMIT - 9'h001)
				timeout <= 1'b1;
			else if (clear)
				timeout <= 1'b0;
		end
	end
endmodule

/* logic/actc_strobe_timer.v */
// Setup, active and recovery sequencer for one strobe cycle
`timescale 1ns/1ps
module actc_strobe_timer (
	input  wire       MCLK,
	input  wire       RST_N,
	input  wire       start,
	input  wire [3:0] setup_cnt,
	input  wire [5:0] active_cnt,
	input  wire [5:0] recov_cnt,
	input  wire       stretch,
	output reg        strobe,
	output reg        busy,
	output reg        done
);
	localparam ST_IDLE   = 2'h0;
	localparam ST_SETUP  = 2'h1;
	localparam ST_ACTIVE = 2'h2;
	localparam ST_RECOV  = 2'h3;

	reg [1:0] state;
	reg [5:0] count;

	// [RULE22] counts are host clocks
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ST_IDLE;
			count <= 6'h00;
			strobe <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (start) begin
					state <= ST_SETUP;
					count <= {2'h0, setup_cnt};
					busy <= 1'b1;
				end
			end
			ST_SETUP: begin
				if (count == 6'h00) begin
					state <= ST_ACTIVE;
					count <= active_cnt;
					strobe <= 1'b1;
				end else begin
					count <= count - 6'h01;
				end
			end
			ST_ACTIVE: begin
				// Drive wait holds the strobe at its last count
				if (count == 6'h00 && !stretch) begin
					state <= ST_RECOV;
					count <= recov_cnt;
					strobe <= 1'b0;
				end else if (count != 6'h00) begin
					count <= count - 6'h01;
				end
			end
			ST_RECOV: begin
				if (count == 6'h00) begin
					state <= ST_IDLE;
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 6'h01;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule

/* logic/actc_channel.v */
// Second-channel timing, configuration and status registers with strobe sequencing
`timescale 1ns/1ps
`include "actc_consts.vh"
//
// Operation
// [RULE1] Word D8 is reserved, read-only, read value unspecified.
// [RULE2] Bus-master PIO mode uses full 32-bit word-aligned byte count.
// [RULE3] PIO read-ahead mode uses only low 16 bits as count.
// [RULE4] Software writes zero to upper count half before read-ahead.
// [RULE5] Task-file address setup comes from config bits 31:28.
// [RULE6] Task-file active from bits 27:22, recovery from 21:16.
// [RULE7] Bit 14 set raises interrupt on watchdog expiry.
// [RULE8] Bit 13 enables or disables the wait-line watchdog.
// [RULE9] Wait deasserted 256 clocks sets timeout, continues, stops watching.
// [RULE10] Write one clears timeout bit 12; watching then resumes.
// [RULE11] Bit 11 shows drive interrupt line live, read-only.
// [RULE12] Bit 10 sets on bus-master completion, clears with start bit.
// [RULE13] Bit 9 enables wait-line watching and stretching of task-file cycles.
// [RULE14] Bits 15 and 8:4 read zero, read-only.
// [RULE15] Bit 3 floats all channel outputs; clear drives normally.
// [RULE16] Bit 2 holds drive reset asserted.
// [RULE17] Bit 1 sets on first command byte, clears when buffer drained.
// [RULE18] Bit 0 shows inverted cable-ID pin.
// [RULE19] PIO data uses per-drive setup, active, recovery fields.
// [RULE20] DMA timing uses same per-drive layout as PIO.
// [RULE21] Drive mode 00..11 selects PIO, PIO wait, DMA, UDMA.
// [RULE22] Counts are host clocks; fields follow the selected drive.
// [RULE23] Watchdog restarts at each deassertion, stops on reassertion.
module actc_channel (
	input  wire        MCLK,
	input  wire        RST_N,
	input  wire [7:0]  REG_ADDR,
	input  wire        REG_WR,
	input  wire        REG_RD,
	input  wire [31:0] REG_WDATA,
	output reg  [31:0] REG_RDATA,
	input  wire [1:0]  MODE_DRV0,
	input  wire [1:0]  MODE_DRV1,
	input  wire        BM_START,
	input  wire        BM_MODE,
	input  wire        XFER_REQ,
	input  wire        XFER_TASKFILE,
	input  wire        XFER_DRIVE,
	input  wire        XFER_DMA,
	output wire        XFER_BUSY,
	output wire        XFER_DONE,
	output reg  [31:0] BYTES_LEFT,
	output wire        BM_COMPLETE,
	input  wire        CMD_BYTE_IN,
	input  wire        BUF_EMPTY,
	input  wire        DRIVE_IRQ,
	input  wire        WAIT_READY,
	input  wire        CABLE_ID_N,
	output wire        STROBE_N,
	output wire        STROBE_OE,
	output wire        DRIVE_RST_N,
	output wire        DRIVE_RST_OE,
	output wire        WD_IRQ
);
	reg  [31:0] read_ahead_byte_count;
	reg  [31:0] cfg;
	reg  [31:0] pio_strobe_timing;
	reg  [31:0] dma_strobe_timing;
	reg         bm_done;
	reg         buf_cmd;
	reg         bm_start_d;
	reg         active_xfer;
	reg  [15:0] pick_timing;
	wire        timeout;
	wire        wd_counting;
	wire        strobe;
	wire        busy;
	wire        done;
	wire [1:0]  drv_mode;
	wire        mode_watch;
	wire        watch_on;
	wire        clear_tmo;
	wire [3:0]  t_setup;
	wire [5:0]  t_active;
	wire [5:0]  t_recov;
	wire [31:0] cfg_view;

	// Selects one drive's 16-bit timing half
	function [15:0] drive_half;
		input [31:0] word;
		input        drv;
		begin
			drive_half = drv ? word[31:16] : word[15:0];
		end
	endfunction

	assign drv_mode = XFER_DRIVE ? MODE_DRV1 : MODE_DRV0;
	// [RULE21] any non-zero mode watches wait line
	assign mode_watch = (drv_mode != `ACTC_MODE_PIO);
	// [RULE13] task-file watch bit
	assign watch_on = XFER_TASKFILE ? cfg[`ACTC_CFG_WATCH] : mode_watch;

	// [RULE5] task-file setup field
	// [RULE6] task-file active and recovery
	// [RULE19] per-drive PIO fields
	// [RULE20] per-drive DMA fields
	// [RULE22] drive select picks half
	always @* begin
		if (XFER_TASKFILE)
			pick_timing = cfg[31:16];
		else if (XFER_DMA)
			pick_timing = drive_half(dma_strobe_timing, XFER_DRIVE);
		else
			pick_timing = drive_half(pio_strobe_timing, XFER_DRIVE);
	end
	assign t_setup = pick_timing[15:12];
	assign t_active = pick_timing[11:6];
	assign t_recov = pick_timing[5:0];

	actc_strobe_timer u_timer (
		.MCLK       (MCLK),
		.RST_N      (RST_N),
		.start      (XFER_REQ & ~busy),
		.setup_cnt  (t_setup),
		.active_cnt (t_active),
		.recov_cnt  (t_recov),
		.stretch    (watch_on & ~XFER_DMA & ~timeout & ~WAIT_READY),
		.strobe     (strobe),
		.busy       (busy),
		.done       (done)
	);

	// [RULE10] write one to bit 12
	assign clear_tmo = REG_WR && REG_ADDR == `ACTC_OFS_CFG && REG_WDATA[`ACTC_CFG_WD_TMO];

	actc_watchdog u_wd (
		.MCLK     (MCLK),
		.RST_N    (RST_N),
		// [RULE8] watchdog enable
		.enable   (cfg[`ACTC_CFG_WD_EN]),
		.watch    (watch_on),
		.in_pio   (busy & ~XFER_DMA & strobe),
		.ready    (WAIT_READY),
		.clear    (clear_tmo),
		.timeout  (timeout),
		.counting (wd_counting)
	);

	// [RULE7] interrupt on expiry
	assign WD_IRQ = cfg[`ACTC_CFG_WD_INT] & timeout;

	assign XFER_BUSY = busy;
	assign XFER_DONE = done;
	// [RULE15] float channel outputs
	assign STROBE_OE = ~cfg[`ACTC_CFG_TRISTATE];
	assign DRIVE_RST_OE = ~cfg[`ACTC_CFG_TRISTATE];
	assign STROBE_N = ~strobe;
	// [RULE16] hold drive reset
	assign DRIVE_RST_N = ~cfg[`ACTC_CFG_CHRST];
	assign BM_COMPLETE = bm_done;

	// [RULE11] live irq, [RULE18] inverted cable pin, [RULE14] zeros
	assign cfg_view = {cfg[31:16], 1'b0, cfg[`ACTC_CFG_WD_INT], cfg[`ACTC_CFG_WD_EN],
		timeout, DRIVE_IRQ, bm_done, cfg[`ACTC_CFG_WATCH], 5'h00,
		cfg[`ACTC_CFG_TRISTATE], cfg[`ACTC_CFG_CHRST], buf_cmd, ~CABLE_ID_N};

	// Register writes and status flags
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			read_ahead_byte_count <= `ACTC_RST_RA_COUNT;
			cfg <= `ACTC_RST_CFG;
			pio_strobe_timing <= `ACTC_RST_PIO;
			dma_strobe_timing <= `ACTC_RST_DMA;
			bm_done <= 1'b0;
			buf_cmd <= 1'b0;
			bm_start_d <= 1'b0;
			active_xfer <= 1'b0;
			BYTES_LEFT <= 32'h00000000;
		end else begin
			bm_start_d <= BM_START;
			if (REG_WR) begin
				case (REG_ADDR)
				`ACTC_OFS_RA_COUNT: read_ahead_byte_count <= REG_WDATA;
				`ACTC_OFS_CFG: cfg <= REG_WDATA & `ACTC_CFG_WMASK;
				`ACTC_OFS_PIO: pio_strobe_timing <= REG_WDATA;
				`ACTC_OFS_DMA: dma_strobe_timing <= REG_WDATA;
				default: cfg <= cfg;
				endcase
			end
			// Count loads on start edge; word aligned, low two bits dropped
			if (BM_START && !bm_start_d) begin
				active_xfer <= 1'b1;
				// [RULE2] full 32-bit count
				// [RULE3] low 16 bits only
				if (BM_MODE)
					BYTES_LEFT <= {read_ahead_byte_count[31:2], 2'h0};
				else
					BYTES_LEFT <= {16'h0000, read_ahead_byte_count[15:2], 2'h0};
			end else if (active_xfer && done && !XFER_TASKFILE) begin
				if (BYTES_LEFT <= 32'h00000004) begin
					BYTES_LEFT <= 32'h00000000;
					active_xfer <= 1'b0;
				end else begin
					BYTES_LEFT <= BYTES_LEFT - 32'h00000004;
				end
			end
			// [RULE12] completion set wins over clear
			if (active_xfer && BM_MODE && done && !XFER_TASKFILE
				&& BYTES_LEFT <= 32'h00000004)
				bm_done <= 1'b1;
			else if (!BM_START)
				bm_done <= 1'b0;
			// [RULE17] buffered command flag
			if (CMD_BYTE_IN)
				buf_cmd <= 1'b1;
			else if (BUF_EMPTY)
				buf_cmd <= 1'b0;
		end
	end

	// [RULE1] reserved word reads zero
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD) begin
			case (REG_ADDR)
			`ACTC_OFS_RSVD: REG_RDATA <= 32'h00000000;
			`ACTC_OFS_RA_COUNT: REG_RDATA <= read_ahead_byte_count;
			`ACTC_OFS_CFG: REG_RDATA <= cfg_view;
			`ACTC_OFS_PIO: REG_RDATA <= pio_strobe_timing;
			`ACTC_OFS_DMA: REG_RDATA <= dma_strobe_timing;
			default: REG_RDATA <= 32'h00000000;
			endcase
		end
	end
endmodule

/* tb/actc_monitor.sv */
// Port-level checker for the channel register block
`timescale 1ns/1ps
module actc_monitor (
	input wire        MCLK,
	input wire        RST_N,
	input wire [7:0]  REG_ADDR,
	input wire        REG_WR,
	input wire        REG_RD,
	input wire [31:0] REG_WDATA,
	input wire [31:0] REG_RDATA,
	input wire        BM_START,
	input wire        BM_COMPLETE,
	input wire        XFER_BUSY,
	input wire        XFER_DONE,
	input wire        DRIVE_IRQ,
	input wire        CABLE_ID_N,
	input wire        STROBE_OE,
	input wire        DRIVE_RST_N,
	input wire        DRIVE_RST_OE
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	wire rd_cfg = REG_RD && REG_ADDR == 8'he0;
	wire wr_cfg = REG_WR && REG_ADDR == 8'he0;
	property p_rsvd; REG_RD && REG_ADDR == 8'hd8 |=> REG_RDATA == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
	property p_zero; rd_cfg |=> REG_RDATA[15] == 1'b0 && REG_RDATA[8:4] == 5'h0; endproperty
	a_zero: assert property (p_zero) else $error("reserved config bits set");
	property p_irq; rd_cfg |=> REG_RDATA[11] == $past(DRIVE_IRQ); endproperty
	a_irq: assert property (p_irq) else $error("interrupt status wrong");
	property p_cable; rd_cfg |=> REG_RDATA[0] == !$past(CABLE_ID_N); endproperty
	a_cable: assert property (p_cable) else $error("cable status wrong");
	property p_float;
		wr_cfg |=> STROBE_OE == !$past(REG_WDATA[3]) && DRIVE_RST_OE == STROBE_OE;
	endproperty
	a_float: assert property (p_float) else $error("float control wrong");
	property p_rst; wr_cfg |=> DRIVE_RST_N == !$past(REG_WDATA[2]); endproperty
	a_rst: assert property (p_rst) else $error("drive reset wrong");
	// The flag clears on the first quiet edge; the second quiet cycle is spare
	property p_bmclr; (!BM_START && !XFER_DONE) [*2] |=> !BM_COMPLETE; endproperty
	a_bmclr: assert property (p_bmclr) else $error("completion flag stuck");
	property p_done; XFER_DONE |-> !XFER_BUSY ##1 !XFER_DONE; endproperty
	a_done: assert property (p_done) else $error("done pulse wrong");
endmodule
bind actc_channel actc_monitor u_mon (.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.BM_START(BM_START), .BM_COMPLETE(BM_COMPLETE), .XFER_BUSY(XFER_BUSY),
	.XFER_DONE(XFER_DONE), .DRIVE_IRQ(DRIVE_IRQ), .CABLE_ID_N(CABLE_ID_N),
	.STROBE_OE(STROBE_OE), .DRIVE_RST_N(DRIVE_RST_N), .DRIVE_RST_OE(DRIVE_RST_OE));

/* tb/actc_drive_model.sv */
// Drive-side model: wait line, interrupt line and cable pin
`timescale 1ns/1ps
module actc_drive_model (
	input  wire       clk,
	input  wire       strobe_n,
	input  wire       strobe_oe,
	input  wire [9:0] stall,
	input  wire       irq,
	input  wire       c80,
	output reg        wait_ready,
	output wire       irq_line,
	output wire       cable_n
);
	reg [9:0] left = 10'h0;
	reg       prev = 1'b1;
	assign irq_line = irq;
	assign cable_n = ~c80;
	always @(posedge clk) begin
		prev <= strobe_n;
		if (prev && !strobe_n && strobe_oe)
			left <= stall;
		else if (left != 10'h0)
			left <= left - 10'h1;
	end
	// Line has a pull-up, so ready whenever not stalling
	always @* wait_ready = (left == 10'h0);
endmodule

/* tb/testbench.sv */
// Self-checking bench for the channel register block
`timescale 1ns/1ps
`include "actc_consts.vh"
module testbench;
	reg MCLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, BM_START = 0, BM_MODE = 0;
	reg XFER_REQ = 0, XFER_TASKFILE = 0, XFER_DRIVE = 0, XFER_DMA = 0;
	reg CMD_BYTE_IN = 0, BUF_EMPTY = 1, irq = 0, c80 = 0;
	reg [7:0] REG_ADDR = 0;
	reg [31:0] REG_WDATA = 0, q;
	reg [1:0] MODE_DRV0 = 0, MODE_DRV1 = 0;
	reg [9:0] stall = 0;
	wire [31:0] REG_RDATA, BYTES_LEFT;
	wire XFER_BUSY, XFER_DONE, BM_COMPLETE, DRIVE_IRQ, WAIT_READY, CABLE_ID_N;
	wire STROBE_N, STROBE_OE, DRIVE_RST_N, DRIVE_RST_OE, WD_IRQ;
	integer n_mismatch = 0, cmp_count = 0, cyc = 0, n, i;
	actc_channel dut (.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.MODE_DRV0(MODE_DRV0), .MODE_DRV1(MODE_DRV1), .BM_START(BM_START),
		.BM_MODE(BM_MODE), .XFER_REQ(XFER_REQ), .XFER_TASKFILE(XFER_TASKFILE),
		.XFER_DRIVE(XFER_DRIVE), .XFER_DMA(XFER_DMA), .XFER_BUSY(XFER_BUSY),
		.XFER_DONE(XFER_DONE), .BYTES_LEFT(BYTES_LEFT), .BM_COMPLETE(BM_COMPLETE),
		.CMD_BYTE_IN(CMD_BYTE_IN), .BUF_EMPTY(BUF_EMPTY), .DRIVE_IRQ(DRIVE_IRQ),
		.WAIT_READY(WAIT_READY), .CABLE_ID_N(CABLE_ID_N), .STROBE_N(STROBE_N),
		.STROBE_OE(STROBE_OE), .DRIVE_RST_N(DRIVE_RST_N), .DRIVE_RST_OE(DRIVE_RST_OE),
		.WD_IRQ(WD_IRQ));
	actc_drive_model u_drv (.clk(MCLK), .strobe_n(STROBE_N), .strobe_oe(STROBE_OE),
		.stall(stall), .irq(irq), .c80(c80), .wait_ready(WAIT_READY),
		.irq_line(DRIVE_IRQ), .cable_n(CABLE_ID_N));
	always #2.5 MCLK = ~MCLK;
	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
			if (n_mismatch == 0 && cmp_count > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// Generous ceiling; whole run needs under a thousand cycles
	always @(posedge MCLK) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			tally_and_finish;
		end
	end
	task cmp(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(negedge MCLK);
			{REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
			@(negedge MCLK);
			REG_WR = 0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(negedge MCLK);
			{REG_ADDR, REG_RD} = {a, 1'b1};
			@(negedge MCLK);
			REG_RD = 0;
			q = REG_RDATA;
		end
	endtask
	// Cycles from the taking edge to the done pulse
	task xfer(input tf, input drv, input dma);
		begin
			@(negedge MCLK);
			{XFER_TASKFILE, XFER_DRIVE, XFER_DMA, XFER_REQ} = {tf, drv, dma, 1'b1};
			@(negedge MCLK);
			XFER_REQ = 0;
			n = 1;
			while (XFER_DONE !== 1'b1 && n < 2000) begin
				@(negedge MCLK);
				n = n + 1;
			end
		end
	endtask
	task t_reset;
		begin
			// Reserved bits 15 and 8:4 read zero even where the reset word has them set
			rd(8'he0); cmp(q, `ACTC_RST_CFG & 32'hffff7e0f);
			rd(8'he4); cmp(q, `ACTC_RST_PIO);
			rd(8'he8); cmp(q, `ACTC_RST_DMA);
			rd(8'hdc); cmp(q, `ACTC_RST_RA_COUNT);
			wr(8'hd8, 32'h5a5a5a5a);
			rd(8'hd8); cmp(q, 32'h0);
			$display("reset values done");
		end
	endtask
	task t_cfg;
		begin
			wr(8'he0, 32'hffffffff);
			rd(8'he0); cmp(q, 32'hffff620c);
			cmp({DRIVE_RST_N, STROBE_OE, DRIVE_RST_OE}, 0);
			wr(8'he0, 32'h10816200);
			cmp({DRIVE_RST_N, STROBE_OE}, 3);
			xfer(1, 1, 0); cmp(n, 8);
			$display("config done");
		end
	endtask
	task t_timing;
		begin
			wr(8'he4, 32'h20c21041);
			wr(8'he8, 32'h30411083);
			xfer(0, 0, 0); cmp(n, 7);
			xfer(0, 1, 0); cmp(n, 11);
			xfer(0, 0, 1); cmp(n, 10);
			xfer(0, 1, 1); cmp(n, 9);
			$display("strobe timing done");
		end
	endtask
	task t_count;
		begin
			wr(8'hdc, 32'h00010010);
			@(negedge MCLK) BM_START = 1;
			repeat (2) @(negedge MCLK);
			cmp(BYTES_LEFT, 32'h10);
			{BM_START, BM_MODE} = 2'b01;
			repeat (2) @(negedge MCLK) BM_START = 1;
			cmp(BYTES_LEFT, 32'h00010010);
			BM_START = 0;
			wr(8'hdc, 32'h8);
			@(negedge MCLK) BM_START = 1;
			xfer(0, 0, 0);
			xfer(0, 0, 0);
			@(negedge MCLK);
			cmp({BYTES_LEFT, BM_COMPLETE}, 1);
			BM_START = 0;
			repeat (3) @(negedge MCLK);
			cmp(BM_COMPLETE, 0);
			$display("byte count done");
		end
	endtask
	task t_watch;
		begin
			stall = 20;
			xfer(1, 0, 0); cmp(n > 8, 1);
			for (i = 0; i < 4; i = i + 1) begin
				MODE_DRV0 = i;
				xfer(0, 0, 0); cmp(n > 7, i != 0);
			end
			MODE_DRV0 = 1;
			stall = 300;
			xfer(0, 0, 0); cmp({WD_IRQ, n < 290}, 3);
			rd(8'he0); cmp(q[12], 1);
			// Clearing the flag while disabling keeps the wait stretched
			wr(8'he0, 32'h10815200);
			cmp(WD_IRQ, 0);
			xfer(0, 0, 0); cmp({WD_IRQ, n > 300}, 1);
			wr(8'he0, 32'h10816200);
			stall = 0;
			$display("watchdog done");
		end
	endtask
	task t_live;
		begin
			{irq, c80, BUF_EMPTY, CMD_BYTE_IN} = 4'b1101;
			@(negedge MCLK) CMD_BYTE_IN = 0;
			rd(8'he0); cmp(q & 32'h803, 32'h803);
			{irq, c80, BUF_EMPTY} = 3'b001;
			rd(8'he0); cmp(q & 32'h803, 0);
			$display("live status done");
		end
	endtask
	initial begin
		repeat (12) @(negedge MCLK);
		RST_N = 1;
		t_reset;
		t_cfg;
		t_timing;
		t_count;
		t_watch;
		t_live;
		tally_and_finish;
	end
endmodule
